/* File: hw/prs_pkg.sv */
// Package with constants, register map and state types of the power resource sequencer.
package prs_pkg;
    // Sizes of the resource set, core clock requests and countdowns.
    localparam int PRS_NUM_RES = 8;
    localparam int PRS_NUM_CLK = 4;
    localparam int PRS_DLY_W = 8;
    localparam int PRS_TMR_W = 16;
    localparam int PRS_ADDR_W = 8;

    // Register byte offsets.
    localparam logic [7:0] PRS_OFF_MIN = 8'h00;
    localparam logic [7:0] PRS_OFF_TMR_MASK = 8'h04;
    localparam logic [7:0] PRS_OFF_TMR_CNT = 8'h08;
    localparam logic [7:0] PRS_OFF_SW_CTRL = 8'h0C;
    localparam logic [7:0] PRS_OFF_STATUS = 8'h10;
    localparam logic [7:0] PRS_OFF_REQUIRED = 8'h14;
    localparam logic [7:0] PRS_OFF_CLKMAP = 8'h40;
    localparam logic [7:0] PRS_OFF_DEP = 8'h60;
    localparam logic [7:0] PRS_OFF_DLY = 8'h80;
    localparam logic [7:0] PRS_WORD = 8'h04;

    // Field positions.
    localparam int PRS_DLY_ON_LSB = 0;
    localparam int PRS_DLY_OFF_LSB = 8;
    localparam int PRS_STAT_TRANS_LSB = 8;
    localparam int PRS_SW_PWM_BIT = 0;
    localparam int PRS_SW_LPB_BIT = 1;

    // AXI responses.
    localparam logic [1:0] PRS_RESP_OKAY = 2'h0;
    localparam logic [1:0] PRS_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PRS_SW_OFF,
        PRS_SW_BURST,
        PRS_SW_PWM,
        PRS_SW_LP_BURST
    } prs_sw_mode_type;

    typedef struct packed {
        logic [PRS_NUM_RES-1:0] min_resource_mask;
        logic [PRS_NUM_RES-1:0] tmr_mask;
        logic [PRS_TMR_W-1:0] tmr_cnt;
        logic [1:0] sw_ctrl;
        logic [PRS_NUM_CLK-1:0][PRS_NUM_RES-1:0] clk_map;
        logic [PRS_NUM_RES-1:0][PRS_NUM_RES-1:0] dep;
        logic [PRS_NUM_RES-1:0][PRS_DLY_W-1:0] on_dly;
        logic [PRS_NUM_RES-1:0][PRS_DLY_W-1:0] off_dly;
    } prs_cfg_type;

    typedef struct packed {
        logic [PRS_NUM_RES-1:0] resource_on_flag;
        logic [PRS_NUM_RES-1:0] resource_transition_flag;
        logic [PRS_NUM_RES-1:0][PRS_DLY_W-1:0] cnt;
        logic slow_d;
        logic shutdown;
        prs_sw_mode_type sw_mode;
    } prs_seq_type;

    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [PRS_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } prs_axi_type;

    typedef struct packed {
        prs_cfg_type cfg;
        prs_seq_type seq;
        prs_axi_type axi;
    } prs_state_type;
endpackage

/* File: hw/prs_top.sv */
// Power resource sequencer with core switcher mode selection and AXI4-Lite registers.
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Requests combine core clock requests, minimum mask and active request timers.
// - Each core clock request expands into its resource set before combining.
// - Each resource is enabled, disabled, turning on or turning off.
// - Countdown is zero when stable and nonzero during a transition.
// - Starting a change loads the enable or disable delay into the countdown.
// - Nonzero countdowns drop by one on each slow oscillator tick.
// - Countdown reaching zero finishes the transition into the stable state.
// - Zero delay switches the resource immediately with no transition.
// - Each cycle first computes the required set, dependencies included.
// - Reaching zero clears the transition flag and inverts the on flag.
// - After timers update, required set is compared with present status.
// - Disable only enabled, unrequested resources without powered dependents.
// - Enable only disabled, requested resources whose dependencies are enabled.
// - In shutdown most outputs float and most inputs are disabled.
// - Leaving shutdown is a fresh power-up with no retained state.
// - Switcher mode follows reset, buck and ripple pins, else internal setting.
// - Buck-on request high turns the core switcher on.
// - Low-power burst is never used while serving only external loads.
// - Countdowns run on the slow sleep oscillator.
// - Either reset pin or buck request high leaves power-down.
module prs_top
    import prs_pkg::*;
#(
    parameter int PAD_W = 8
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [PRS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [PRS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Host pins and slow clock.
    input wire logic wlan_core_reset_low_pin,
    input wire logic ext_buck_on_request,
    input wire logic ext_low_ripple_request,
    input wire logic slow_sleep_oscillator,
    // Core clock requests.
    input wire logic [PRS_NUM_CLK-1:0] core_clk_req,
    // Resource and switcher controls.
    output logic [PRS_NUM_RES-1:0] resource_enable,
    output prs_sw_mode_type core_switcher_mode,
    // Pad controls for shutdown.
    output logic [PAD_W-1:0] pad_oe_n,
    output logic pad_input_enable
);

    prs_state_type s_r;
    prs_state_type s_nxt;
    logic [PRS_NUM_RES-1:0] required;
    logic [PRS_NUM_RES-1:0] cnt_nz;
    logic slow_tick;
    logic wr_fire;

    ////////////////////////////////////////////////////////////////////////////
    // Register read decode; unmapped addresses answer SLVERR with zero data.
    function automatic logic [32:0] reg_read(input prs_state_type st,
                                             input logic [PRS_NUM_RES-1:0] req,
                                             input logic [PRS_ADDR_W-1:0] a);
        logic [32:0] r;
        r = '0;
        if (a == PRS_OFF_MIN) begin
            r = {1'b1, 24'h00_0000, st.cfg.min_resource_mask};
        end else if (a == PRS_OFF_TMR_MASK) begin
            r = {1'b1, 24'h00_0000, st.cfg.tmr_mask};
        end else if (a == PRS_OFF_TMR_CNT) begin
            r = {1'b1, 16'h0000, st.cfg.tmr_cnt};
        end else if (a == PRS_OFF_SW_CTRL) begin
            r = {1'b1, 30'h0000_0000, st.cfg.sw_ctrl};
        end else if (a == PRS_OFF_STATUS) begin
            r = {1'b1, 16'h0000, st.seq.resource_transition_flag, st.seq.resource_on_flag};
        end else if (a == PRS_OFF_REQUIRED) begin
            r = {1'b1, 24'h00_0000, req};
        end
        for (int i = 0; i < PRS_NUM_CLK; i++) begin
            if (a == 8'(PRS_OFF_CLKMAP + PRS_WORD * 8'(i))) begin
                r = {1'b1, 24'h00_0000, st.cfg.clk_map[i]};
            end
        end
        for (int i = 0; i < PRS_NUM_RES; i++) begin
            if (a == 8'(PRS_OFF_DEP + PRS_WORD * 8'(i))) begin
                r = {1'b1, 24'h00_0000, st.cfg.dep[i]};
            end
            if (a == 8'(PRS_OFF_DLY + PRS_WORD * 8'(i))) begin
                r = {1'b1, 16'h0000, st.cfg.off_dly[i], st.cfg.on_dly[i]};
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Handshake outputs are combinational; a new write is held off until its
    // response is taken so that only one write is ever outstanding.
    assign s_axi_awready = !s_r.axi.aw_got && !s_r.axi.bvalid;
    assign s_axi_wready = !s_r.axi.w_got && !s_r.axi.bvalid;
    assign s_axi_arready = !s_r.axi.rvalid;
    assign s_axi_bvalid = s_r.axi.bvalid;
    assign s_axi_bresp = s_r.axi.bresp;
    assign s_axi_rvalid = s_r.axi.rvalid;
    assign s_axi_rdata = s_r.axi.rdata;
    assign s_axi_rresp = s_r.axi.rresp;

    assign resource_enable = s_r.seq.resource_on_flag;
    assign core_switcher_mode = s_r.seq.sw_mode;
    assign pad_oe_n = {PAD_W{s_r.seq.shutdown}};
    assign pad_input_enable = !s_r.seq.shutdown;

    assign slow_tick = slow_sleep_oscillator && !s_r.seq.slow_d;
    assign wr_fire = s_r.axi.aw_got && s_r.axi.w_got && !s_r.axi.bvalid;

    always_comb begin
        for (int i = 0; i < PRS_NUM_RES; i++) begin
            cnt_nz[i] = s_r.seq.cnt[i] != '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Required set: sources first, then the dependency closure in as many
    // passes as there are resources so that chains of any depth are covered.
    always_comb begin
        required = s_r.cfg.min_resource_mask;
        if (s_r.cfg.tmr_cnt != '0) begin
            required = required | s_r.cfg.tmr_mask;
        end
        for (int c = 0; c < PRS_NUM_CLK; c++) begin
            if (core_clk_req[c]) begin
                required = required | s_r.cfg.clk_map[c];
            end
        end
        for (int k = 0; k < PRS_NUM_RES; k++) begin
            for (int i = 0; i < PRS_NUM_RES; i++) begin
                if (required[i]) begin
                    required = required | s_r.cfg.dep[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [32:0] rd;
        logic [31:0] wv;
        logic hit;
        logic busy_dep;
        logic deps_ok;
        rd = '0;
        wv = '0;
        hit = 1'b0;
        busy_dep = 1'b0;
        deps_ok = 1'b0;
        s_nxt = s_r;

        // Bus slave.
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.axi.aw_got = 1'b1;
            s_nxt.axi.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.axi.w_got = 1'b1;
            s_nxt.axi.wdata = s_axi_wdata;
            s_nxt.axi.wstrb = s_axi_wstrb;
        end
        if (s_r.axi.bvalid && s_axi_bready) begin
            s_nxt.axi.bvalid = 1'b0;
        end
        if (s_r.axi.rvalid && s_axi_rready) begin
            s_nxt.axi.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rd = reg_read(s_r, required, s_axi_araddr);
            s_nxt.axi.rvalid = 1'b1;
            s_nxt.axi.rdata = rd[31:0];
            s_nxt.axi.rresp = rd[32] ? PRS_RESP_OKAY : PRS_RESP_SLVERR;
        end

        // Request timer counts down on slow ticks while it is active.
        s_nxt.seq.slow_d = slow_sleep_oscillator;
        if (slow_tick && s_r.cfg.tmr_cnt != '0) begin
            s_nxt.cfg.tmr_cnt = s_r.cfg.tmr_cnt - 1'b1;
        end

        if (wr_fire) begin
            rd = reg_read(s_r, required, s_r.axi.awaddr);
            hit = rd[32];
            wv = merge(rd[31:0], s_r.axi.wdata, s_r.axi.wstrb);
            s_nxt.axi.aw_got = 1'b0;
            s_nxt.axi.w_got = 1'b0;
            s_nxt.axi.bvalid = 1'b1;
            s_nxt.axi.bresp = hit ? PRS_RESP_OKAY : PRS_RESP_SLVERR;
            if (s_r.axi.awaddr == PRS_OFF_MIN) begin
                s_nxt.cfg.min_resource_mask = wv[PRS_NUM_RES-1:0];
            end
            if (s_r.axi.awaddr == PRS_OFF_TMR_MASK) begin
                s_nxt.cfg.tmr_mask = wv[PRS_NUM_RES-1:0];
            end
            if (s_r.axi.awaddr == PRS_OFF_TMR_CNT) begin
                s_nxt.cfg.tmr_cnt = wv[PRS_TMR_W-1:0];
            end
            if (s_r.axi.awaddr == PRS_OFF_SW_CTRL) begin
                s_nxt.cfg.sw_ctrl = wv[1:0];
            end
            for (int i = 0; i < PRS_NUM_CLK; i++) begin
                if (s_r.axi.awaddr == 8'(PRS_OFF_CLKMAP + PRS_WORD * 8'(i))) begin
                    s_nxt.cfg.clk_map[i] = wv[PRS_NUM_RES-1:0];
                end
            end
            for (int i = 0; i < PRS_NUM_RES; i++) begin
                if (s_r.axi.awaddr == 8'(PRS_OFF_DEP + PRS_WORD * 8'(i))) begin
                    s_nxt.cfg.dep[i] = wv[PRS_NUM_RES-1:0];
                end
                if (s_r.axi.awaddr == 8'(PRS_OFF_DLY + PRS_WORD * 8'(i))) begin
                    s_nxt.cfg.on_dly[i] = wv[PRS_DLY_ON_LSB +: PRS_DLY_W];
                    s_nxt.cfg.off_dly[i] = wv[PRS_DLY_OFF_LSB +: PRS_DLY_W];
                end
            end
        end

        // Timer step: every nonzero countdown moves on a slow tick.
        for (int i = 0; i < PRS_NUM_RES; i++) begin
            if (slow_tick && cnt_nz[i]) begin
                s_nxt.seq.cnt[i] = s_r.seq.cnt[i] - 1'b1;
                if (s_r.seq.cnt[i] == PRS_DLY_W'(1)) begin
                    s_nxt.seq.resource_transition_flag[i] = 1'b0;
                    s_nxt.seq.resource_on_flag[i] = !s_r.seq.resource_on_flag[i];
                end
            end
        end

        // Compare against the status just updated and start sequences.
        for (int i = 0; i < PRS_NUM_RES; i++) begin
            busy_dep = 1'b0;
            for (int j = 0; j < PRS_NUM_RES; j++) begin
                if (s_r.cfg.dep[j][i] && (s_nxt.seq.resource_on_flag[j] ||
                    s_nxt.seq.resource_transition_flag[j])) begin
                    busy_dep = 1'b1;
                end
            end
            deps_ok = ((s_r.cfg.dep[i] & ~s_nxt.seq.resource_on_flag) == '0) &&
                      ((s_r.cfg.dep[i] & s_nxt.seq.resource_transition_flag) == '0);
            if (!s_nxt.seq.resource_transition_flag[i]) begin
                if (s_nxt.seq.resource_on_flag[i] && !required[i] && !busy_dep) begin
                    if (s_r.cfg.off_dly[i] == '0) begin
                        s_nxt.seq.resource_on_flag[i] = 1'b0;
                    end else begin
                        s_nxt.seq.resource_transition_flag[i] = 1'b1;
                        s_nxt.seq.cnt[i] = s_r.cfg.off_dly[i];
                    end
                end else if (!s_nxt.seq.resource_on_flag[i] && required[i] && deps_ok) begin
                    if (s_r.cfg.on_dly[i] == '0) begin
                        s_nxt.seq.resource_on_flag[i] = 1'b1;
                    end else begin
                        s_nxt.seq.resource_transition_flag[i] = 1'b1;
                        s_nxt.seq.cnt[i] = s_r.cfg.on_dly[i];
                    end
                end
            end
        end

        // Switcher mode selection from pins and internal setting.
        if (!wlan_core_reset_low_pin) begin
            if (!ext_buck_on_request) begin
                s_nxt.seq.sw_mode = PRS_SW_OFF;
            end else if (ext_low_ripple_request) begin
                s_nxt.seq.sw_mode = PRS_SW_PWM;
            end else begin
                s_nxt.seq.sw_mode = PRS_SW_BURST;
            end
        end else if (ext_buck_on_request && ext_low_ripple_request) begin
            s_nxt.seq.sw_mode = PRS_SW_PWM;
        end else if (s_r.cfg.sw_ctrl[PRS_SW_PWM_BIT]) begin
            s_nxt.seq.sw_mode = PRS_SW_PWM;
        end else if (s_r.cfg.sw_ctrl[PRS_SW_LPB_BIT]) begin
            s_nxt.seq.sw_mode = PRS_SW_LP_BURST;
        end else begin
            s_nxt.seq.sw_mode = PRS_SW_BURST;
        end
        s_nxt.seq.shutdown = !wlan_core_reset_low_pin && !ext_buck_on_request;

        // Core in reset: drop every resource and all settings, so power-up
        // afterwards starts exactly as from cold; the bus keeps answering.
        if (!wlan_core_reset_low_pin) begin
            s_nxt.cfg = '0;
            s_nxt.seq.resource_on_flag = '0;
            s_nxt.seq.resource_transition_flag = '0;
            s_nxt.seq.cnt = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_cnt_matches_flag;
        s_r.seq.resource_transition_flag == cnt_nz;
    endproperty
    a_cnt_matches_flag: assert property (p_cnt_matches_flag) else $error("countdown and flag disagree");

    property p_tick_decrements;
        wlan_core_reset_low_pin && slow_tick && s_r.seq.cnt[0] > PRS_DLY_W'(1) |=>
            s_r.seq.cnt[0] == $past(s_r.seq.cnt[0]) - 1'b1;
    endproperty
    a_tick_decrements: assert property (p_tick_decrements) else $error("countdown did not step");

    property p_hold_without_tick;
        !slow_tick && cnt_nz[0] && wlan_core_reset_low_pin |=>
            s_r.seq.cnt[0] == $past(s_r.seq.cnt[0]);
    endproperty
    a_hold_without_tick: assert property (p_hold_without_tick) else $error("countdown moved without tick");

    property p_finish_transition;
        wlan_core_reset_low_pin && slow_tick && s_r.seq.cnt[0] == PRS_DLY_W'(1) |=>
            (!s_r.seq.resource_transition_flag[0] &&
            s_r.seq.resource_on_flag[0] != $past(s_r.seq.resource_on_flag[0])) ||
            $past(required[0]) == $past(s_r.seq.resource_on_flag[0]);
    endproperty
    a_finish_transition: assert property (p_finish_transition) else $error("transition end wrong");
    property p_direct_on;
        $rose(s_r.seq.resource_on_flag[1]) && !$past(s_r.seq.resource_transition_flag[1]) |->
            $past(s_r.cfg.on_dly[1]) == '0;
    endproperty
    a_direct_on: assert property (p_direct_on) else $error("immediate enable with delay set");

    property p_enable_load;
        $rose(s_r.seq.resource_transition_flag[0]) && !s_r.seq.resource_on_flag[0] |->
            s_r.seq.cnt[0] == $past(s_r.cfg.on_dly[0]) && $past(required[0]);
    endproperty
    a_enable_load: assert property (p_enable_load) else $error("enable start wrong");

    property p_disable_load;
        $rose(s_r.seq.resource_transition_flag[0]) && s_r.seq.resource_on_flag[0] |->
            s_r.seq.cnt[0] == $past(s_r.cfg.off_dly[0]) && !$past(required[0]);
    endproperty
    a_disable_load: assert property (p_disable_load) else $error("disable start wrong");

    property p_switch_off;
        !wlan_core_reset_low_pin && !ext_buck_on_request |=>
            core_switcher_mode == PRS_SW_OFF && pad_oe_n == {PAD_W{1'b1}};
    endproperty
    a_switch_off: assert property (p_switch_off) else $error("shutdown not applied");

    property p_both_pwm;
        ext_buck_on_request && ext_low_ripple_request |=> core_switcher_mode == PRS_SW_PWM;
    endproperty
    a_both_pwm: assert property (p_both_pwm) else $error("switcher not in pwm");

    property p_no_lpb_external;
        !wlan_core_reset_low_pin |=> core_switcher_mode != PRS_SW_LP_BURST &&
            resource_enable == '0;
    endproperty
    a_no_lpb_external: assert property (p_no_lpb_external) else $error("external-only mode wrong");

    property p_wake;
        wlan_core_reset_low_pin || ext_buck_on_request |=> !s_r.seq.shutdown && pad_input_enable;
    endproperty
    a_wake: assert property (p_wake) else $error("power-down not left");

endmodule

/* File: verification/prs_host_model.sv */
// Host side model that drives the core reset, switcher request pins and the slow clock.
`timescale 1ns/1ps

module prs_host_model #(
    parameter int SETTLE_CYC = 25000
) (
    // Clock.
    input wire logic aclk,
    // Host pins and slow clock.
    output logic wlan_core_reset_low_pin,
    output logic ext_buck_on_request,
    output logic ext_low_ripple_request,
    output logic slow_sleep_oscillator
);
    // The host starts with the wireless core held in reset.
    initial begin
        wlan_core_reset_low_pin = 1'h0;
        ext_buck_on_request = 1'h0;
        ext_low_ripple_request = 1'h0;
        slow_sleep_oscillator = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic pins(input logic rst, input logic buck, input logic rip);
        logic rise;
        @(posedge aclk);
        rise = rip & ~ext_low_ripple_request;
        wlan_core_reset_low_pin <= rst;
        ext_buck_on_request <= buck;
        ext_low_ripple_request <= rip;
        // Load may only grow once the ripple loop has had time to settle.
        if (rise) begin
            repeat (SETTLE_CYC) @(posedge aclk);
        end
    endtask

    // One slow tick, held for several fast cycles like a real slow clock.
    task automatic tick();
        @(posedge aclk);
        slow_sleep_oscillator <= 1'h1;
        repeat (4) @(posedge aclk);
        slow_sleep_oscillator <= 1'h0;
        repeat (4) @(posedge aclk);
    endtask
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the power resource sequencer.
`timescale 1ns/1ps

module tb_top;
    import prs_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, wlan_core_reset_low_pin, ext_buck_on_request;
    logic ext_low_ripple_request, slow_sleep_oscillator, pad_input_enable;
    logic [7:0] s_axi_awaddr, s_axi_araddr, resource_enable, pad_oe_n;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, core_clk_req;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
    prs_sw_mode_type core_switcher_mode, em;
    int mismatches = 0;
    int n_checks = 0;

    prs_top #(.PAD_W(8)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .wlan_core_reset_low_pin, .ext_buck_on_request, .ext_low_ripple_request,
        .slow_sleep_oscillator, .core_clk_req, .resource_enable, .core_switcher_mode,
        .pad_oe_n, .pad_input_enable);
    prs_host_model #(.SETTLE_CYC(25)) u_host (.aclk, .wlan_core_reset_low_pin,
        .ext_buck_on_request, .ext_low_ripple_request, .slow_sleep_oscillator);

    initial begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        b = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    // Registers are lost while the core pin is low, so the mode is rewritten in each row that drives the core pin high.
    task automatic t_mode();
        for (int i = 0; i < 16; i++) begin
            u_host.pins(i[3], i[2], i[1]);
            if (i[3]) wr(PRS_OFF_SW_CTRL, {31'h0, i[0]});
            repeat (3) @(posedge aclk);
            if (!i[3]) em = i[2] ? (i[1] ? PRS_SW_PWM : PRS_SW_BURST) : PRS_SW_OFF;
            else em = (i[2] && i[1]) || i[0] ? PRS_SW_PWM : PRS_SW_BURST;
            chk({30'h0, core_switcher_mode}, {30'h0, em});
        end
        u_host.pins(1'h1, 1'h0, 1'h0);
        wr(PRS_OFF_SW_CTRL, 32'h0000_0002);
        repeat (3) @(posedge aclk);
        chk({30'h0, core_switcher_mode}, {30'h0, PRS_SW_LP_BURST});
        $display("test mode table done");
    endtask

    task automatic t_seq();
        wr(8'h80, 32'h0000_0102);
        wr(8'h64, 32'h0000_0001);
        wr(PRS_OFF_MIN, 32'h0000_0002);
        rd(PRS_OFF_REQUIRED);
        chk(d, 32'h0000_0003);
        rd(PRS_OFF_STATUS);
        chk(d, 32'h0000_0100);
        u_host.tick();
        rd(PRS_OFF_STATUS);
        chk(d, 32'h0000_0100);
        u_host.tick();
        rd(PRS_OFF_STATUS);
        chk(d, 32'h0000_0003);
        wr(PRS_OFF_MIN, 32'h0000_0000);
        repeat (4) @(posedge aclk);
        rd(PRS_OFF_STATUS);
        chk(d, 32'h0000_0101);
        u_host.tick();
        chk({24'h0, resource_enable}, 32'h0000_0000);
        $display("test sequencing done");
    endtask

    task automatic t_src();
        wr(8'h48, 32'h0000_0004);
        core_clk_req <= 4'h4;
        repeat (4) @(posedge aclk);
        chk({24'h0, resource_enable}, 32'h0000_0004);
        core_clk_req <= 4'h0;
        wr(PRS_OFF_TMR_MASK, 32'h0000_0008);
        wr(PRS_OFF_TMR_CNT, 32'h0000_0001);
        chk({30'h0, b}, {30'h0, PRS_RESP_OKAY});
        repeat (4) @(posedge aclk);
        chk({24'h0, resource_enable}, 32'h0000_0008);
        u_host.tick();
        chk({24'h0, resource_enable}, 32'h0000_0000);
        rd(8'hFC);
        chk({30'h0, r}, {30'h0, PRS_RESP_SLVERR});
        chk(d, 32'h0000_0000);
        wr(8'hFC, 32'h0000_0001);
        chk({30'h0, b}, {30'h0, PRS_RESP_SLVERR});
        $display("test request sources done");
    endtask

    task automatic t_shut();
        wr(PRS_OFF_MIN, 32'h0000_0001);
        u_host.pins(1'h0, 1'h0, 1'h0);
        repeat (3) @(posedge aclk);
        chk({23'h0, pad_input_enable, pad_oe_n}, 32'h0000_00FF);
        u_host.pins(1'h1, 1'h0, 1'h0);
        repeat (3) @(posedge aclk);
        chk({23'h0, pad_input_enable, pad_oe_n}, 32'h0000_0100);
        rd(PRS_OFF_MIN);
        chk(d, 32'h0000_0000);
        chk({24'h0, resource_enable}, 32'h0000_0000);
        $display("test shutdown done");
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        core_clk_req = 4'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
        chk({24'h0, resource_enable}, 32'h0000_0000);
        chk({23'h0, pad_input_enable, pad_oe_n}, 32'h0000_00FF);
        t_mode();
        t_seq();
        t_src();
        t_shut();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        complete_run();
    end
endmodule
